// [core/freq_protection_supervision.sv]
// Purpose: frequency protection supervision with six definite-time stages
// Assumes: freq in 0.01 Hz, voltages in 0.1 V, cycle_tick once per power cycle
// Notes: registers on AHB-Lite, zero wait states, always OKAY
// Contract
// - outside 40-70 Hz inhibit all but stages
// - separate flags for below and above range
// - setting enables or disables undervoltage blocking
// - undervoltage blocks everything, stages included
// - release only above threshold plus five percent
// - flag while undervoltage blocking is active
// - rate element picks up after N cycles
// - rate element resets after M cycles below
// - cycle counts shared by all rate elements
// - one holding timer, 1 to 300 s
// - six stages, own enable, threshold, delay
// - below nominal underfrequency, above nominal overfrequency
// - threshold equal to nominal flags invalid setting
// - zero delay trips at once
// - per-stage start and trip flags
// - aggregate start and trip as OR
// - defaults give four under, two over stages
`timescale 1ns/1ps

module freq_protection_supervision #(
    parameter int TICK_CYCLES = freq_prot_pkg::TICK_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [15:0] freq,
    input wire logic [15:0] volt_ab,
    input wire logic [15:0] volt_bc,
    input wire logic [15:0] volt_ca,
    input wire logic cycle_tick,
    input wire logic [7:0] roc_exceed,
    output logic [7:0] roc_valid,
    output logic [8:0] holding_time,
    output logic [5:0] stage_start,
    output logic [5:0] stage_trip,
    output logic any_start,
    output logic any_trip,
    output logic freq_below_range,
    output logic freq_above_range,
    output logic uv_block_active,
    output logic setting_invalid,
    output logic irq
);

    typedef struct packed {
        logic uv_enable;
        logic [15:0] nominal;
        logic [15:0] uv_thresh;
        logic [3:0] pickup;
        logic [1:0] dropoff;
        logic [8:0] hold_time;
        logic [5:0] stage_en;
        logic [5:0][15:0] stage_freq;
        logic [5:0][15:0] stage_delay;
        logic [4:0] irq_status;
        logic [4:0] irq_mask;
        logic [4:0] event_prev;
        logic uv_block;
        logic freq_low;
        logic freq_high;
        logic invalid;
        logic [7:0][3:0] pick_cnt;
        logic [7:0][1:0] drop_cnt;
        logic [7:0] roc_valid;
        logic [16:0] prescale;
        logic tick;
        logic wr_pending;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
    } state_type;

    localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);

    state_type state;
    state_type next_state;
    logic [5:0] start_w;
    logic [5:0] trip_w;

    // ------------------------------------------------------------
    // definite-time stages
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < freq_prot_pkg::STAGES; g++) begin : stage_gen
            freq_stage stage_inst (
                .sys_clk(sys_clk),
                .rst(rst),
                .enable(state.stage_en[g]),
                .threshold(state.stage_freq[g]),
                .nominal(state.nominal),
                .delay(state.stage_delay[g]),
                .freq(freq),
                .block(state.uv_block),
                .tick(state.tick),
                .start(start_w[g]),
                .trip(trip_w[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic [21:0] scaled_ab;
    logic [21:0] scaled_bc;
    logic [21:0] scaled_ca;
    logic [21:0] scaled_thr;
    logic any_low;
    logic all_clear;
    logic roc_block;
    logic [4:0] events;
    logic [4:0] clear_bits;
    logic addr_phase;
    logic [7:0] raddr;
    logic [31:0] rd;
    logic [31:0] wd;
    int idx;

    always_comb begin
        next_state = state;
        clear_bits = 5'h00;
        wd = hwdata;
        idx = 0;

        // delay step prescaler
        next_state.tick = 1'b0;
        if (state.prescale >= TICK_LAST) begin
            next_state.prescale = 17'h00000;
            next_state.tick = 1'b1;
        end else begin
            next_state.prescale = state.prescale + 17'h00001;
        end

        // frequency tracking range
        next_state.freq_low = freq < freq_prot_pkg::TRACK_LOW;
        next_state.freq_high = freq > freq_prot_pkg::TRACK_HIGH;

        // undervoltage blocking with hysteresis
        any_low = (volt_ab < state.uv_thresh) || (volt_bc < state.uv_thresh) ||
            (volt_ca < state.uv_thresh);
        scaled_ab = 22'(volt_ab) * 22'(freq_prot_pkg::HYST_DEN);
        scaled_bc = 22'(volt_bc) * 22'(freq_prot_pkg::HYST_DEN);
        scaled_ca = 22'(volt_ca) * 22'(freq_prot_pkg::HYST_DEN);
        scaled_thr = 22'(state.uv_thresh) * 22'(freq_prot_pkg::HYST_NUM);
        all_clear = (scaled_ab > scaled_thr) && (scaled_bc > scaled_thr) &&
            (scaled_ca > scaled_thr);
        if (!state.uv_enable) begin
            next_state.uv_block = 1'b0;
        end else if (any_low) begin
            next_state.uv_block = 1'b1;
        end else if (all_clear) begin
            next_state.uv_block = 1'b0;
        end

        // invalid stage setting
        next_state.invalid = 1'b0;
        for (idx = 0; idx < freq_prot_pkg::STAGES; idx++) begin
            if (state.stage_freq[idx] == state.nominal) begin
                next_state.invalid = 1'b1;
            end
        end

        // rate-of-change pick-up and drop-off qualification
        roc_block = state.freq_low || state.freq_high || state.uv_block;
        if (roc_block) begin
            next_state.roc_valid = 8'h00;
            next_state.pick_cnt = '0;
            next_state.drop_cnt = '0;
        end else if (cycle_tick) begin
            for (idx = 0; idx < freq_prot_pkg::ROC_ELEMENTS; idx++) begin
                if (roc_exceed[idx]) begin
                    next_state.drop_cnt[idx] = 2'h0;
                    if (!state.roc_valid[idx]) begin
                        next_state.pick_cnt[idx] = state.pick_cnt[idx] + 4'h1;
                        if (state.pick_cnt[idx] + 4'h1 >= state.pickup) begin
                            next_state.roc_valid[idx] = 1'b1;
                            next_state.pick_cnt[idx] = 4'h0;
                        end
                    end
                end else begin
                    next_state.pick_cnt[idx] = 4'h0;
                    if (state.roc_valid[idx]) begin
                        next_state.drop_cnt[idx] = state.drop_cnt[idx] + 2'h1;
                        if (state.drop_cnt[idx] + 2'h1 >= state.dropoff) begin
                            next_state.roc_valid[idx] = 1'b0;
                            next_state.drop_cnt[idx] = 2'h0;
                        end
                    end
                end
            end
        end

        // bus address phase: read data registered for the data phase
        addr_phase = hsel && htrans[1] && hready;
        raddr = haddr[7:0];
        rd = 32'h00000000;
        case (raddr)
            freq_prot_pkg::CTRL_ADDR: rd = {31'h00000000, state.uv_enable};
            freq_prot_pkg::NOMINAL_ADDR: rd = {16'h0000, state.nominal};
            freq_prot_pkg::UV_THRESH_ADDR: rd = {16'h0000, state.uv_thresh};
            freq_prot_pkg::ROC_CYCLES_ADDR: begin
                rd = {22'h000000, state.dropoff, 4'h0, state.pickup};
            end
            freq_prot_pkg::HOLD_TIMER_ADDR: rd = {23'h000000, state.hold_time};
            freq_prot_pkg::STATUS_ADDR: begin
                rd = {state.roc_valid, 6'h00, trip_w, 2'h0, start_w,
                    state.invalid, state.uv_block, state.freq_high, state.freq_low};
            end
            freq_prot_pkg::IRQ_STATUS_ADDR: rd = {27'h0000000, state.irq_status};
            freq_prot_pkg::IRQ_MASK_ADDR: rd = {27'h0000000, state.irq_mask};
            default: begin
                if (raddr >= freq_prot_pkg::STAGE_BASE_ADDR &&
                    raddr <= freq_prot_pkg::STAGE_LAST_ADDR) begin
                    idx = int'(raddr[6:3]) - 4;
                    if (raddr[2]) begin
                        rd = {16'h0000, state.stage_delay[idx]};
                    end else begin
                        rd = {state.stage_en[idx], 15'h0000, state.stage_freq[idx]};
                    end
                end
            end
        endcase
        if (addr_phase && !hwrite) begin
            next_state.rdata = rd;
        end
        next_state.wr_pending = addr_phase && hwrite;
        if (addr_phase) begin
            next_state.wr_addr = raddr;
        end

        // bus data phase: register writes
        if (state.wr_pending) begin
            case (state.wr_addr)
                freq_prot_pkg::CTRL_ADDR: next_state.uv_enable = wd[0];
                freq_prot_pkg::NOMINAL_ADDR: next_state.nominal = wd[15:0];
                freq_prot_pkg::UV_THRESH_ADDR: next_state.uv_thresh = wd[15:0];
                freq_prot_pkg::ROC_CYCLES_ADDR: begin
                    if (wd[3:0] < freq_prot_pkg::PICKUP_MIN) begin
                        next_state.pickup = freq_prot_pkg::PICKUP_MIN;
                    end else if (wd[3:0] > freq_prot_pkg::PICKUP_MAX) begin
                        next_state.pickup = freq_prot_pkg::PICKUP_MAX;
                    end else begin
                        next_state.pickup = wd[3:0];
                    end
                    if (wd[freq_prot_pkg::DROPOFF_LSB +: 2] < freq_prot_pkg::DROPOFF_MIN) begin
                        next_state.dropoff = freq_prot_pkg::DROPOFF_MIN;
                    end else begin
                        next_state.dropoff = wd[freq_prot_pkg::DROPOFF_LSB +: 2];
                    end
                end
                freq_prot_pkg::HOLD_TIMER_ADDR: begin
                    if (wd[8:0] < freq_prot_pkg::HOLD_MIN || wd[31:9] != 23'h000000) begin
                        next_state.hold_time = (wd[31:9] != 23'h000000) ?
                            freq_prot_pkg::HOLD_MAX : freq_prot_pkg::HOLD_MIN;
                    end else if (wd[8:0] > freq_prot_pkg::HOLD_MAX) begin
                        next_state.hold_time = freq_prot_pkg::HOLD_MAX;
                    end else begin
                        next_state.hold_time = wd[8:0];
                    end
                end
                freq_prot_pkg::IRQ_STATUS_ADDR: clear_bits = wd[4:0];
                freq_prot_pkg::IRQ_MASK_ADDR: next_state.irq_mask = wd[4:0];
                default: begin
                    if (state.wr_addr >= freq_prot_pkg::STAGE_BASE_ADDR &&
                        state.wr_addr <= freq_prot_pkg::STAGE_LAST_ADDR) begin
                        idx = int'(state.wr_addr[6:3]) - 4;
                        if (state.wr_addr[2]) begin
                            next_state.stage_delay[idx] = wd[15:0];
                        end else begin
                            next_state.stage_en[idx] = wd[freq_prot_pkg::STAGE_EN_BIT];
                            next_state.stage_freq[idx] = wd[15:0];
                        end
                    end
                end
            endcase
        end

        // sticky event bits: a new event wins over a write-one clear
        events = {state.invalid, state.freq_low || state.freq_high, state.uv_block,
            |start_w, |trip_w};
        next_state.event_prev = events;
        next_state.irq_status = (state.irq_status & ~clear_bits) |
            (events & ~state.event_prev);
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= '0;
            state.uv_enable <= freq_prot_pkg::UV_ENABLE_RESET;
            state.nominal <= freq_prot_pkg::NOMINAL_RESET;
            state.uv_thresh <= freq_prot_pkg::UV_THRESH_RESET;
            state.pickup <= freq_prot_pkg::PICKUP_RESET;
            state.dropoff <= freq_prot_pkg::DROPOFF_RESET;
            state.hold_time <= freq_prot_pkg::HOLD_RESET;
            state.stage_en <= freq_prot_pkg::STAGE_EN_RESET;
            state.stage_freq <= freq_prot_pkg::STAGE_FREQ_RESET;
            state.stage_delay <= freq_prot_pkg::STAGE_DELAY_RESET;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = state.rdata;
    assign roc_valid = state.roc_valid;
    assign holding_time = state.hold_time;
    assign stage_start = start_w;
    assign stage_trip = trip_w;
    assign any_start = |start_w;
    assign any_trip = |trip_w;
    assign freq_below_range = state.freq_low;
    assign freq_above_range = state.freq_high;
    assign uv_block_active = state.uv_block;
    assign setting_invalid = state.invalid;
    assign irq = |(state.irq_status & state.irq_mask);

endmodule // freq_protection_supervision

// [core/freq_stage.sv]
// Purpose: one definite-time under/over-frequency stage
// Assumes: tick pulses once per 0.01 s delay step
// Notes: direction follows threshold against nominal
`timescale 1ns/1ps

module freq_stage (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic [15:0] threshold,
    input wire logic [15:0] nominal,
    input wire logic [15:0] delay,
    input wire logic [15:0] freq,
    input wire logic block,
    input wire logic tick,
    output logic start,
    output logic trip
);

    typedef struct packed {
        logic [15:0] count;
        logic start;
        logic trip;
    } stage_state_type;

    stage_state_type state;
    stage_state_type next_state;
    logic under;
    logic cond;

    // ------------------------------------------------------------
    // pick-up condition and timer
    // ------------------------------------------------------------
    always_comb begin
        under = threshold < nominal;
        cond = enable && !block && (threshold != nominal) &&
            (under ? (freq < threshold) : (freq > threshold));
        next_state = state;
        next_state.start = cond;
        if (!cond) begin
            next_state.count = 16'h0000;
            next_state.trip = 1'b0;
        end else if (delay == 16'h0000) begin
            next_state.trip = 1'b1;
        end else if (tick && !state.trip) begin
            next_state.count = state.count + 16'h0001;
            if (state.count + 16'h0001 >= delay) begin
                next_state.trip = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign start = state.start;
    assign trip = state.trip;

endmodule // freq_stage

// [include/freq_prot_pkg.sv]
// Purpose: shared constants for the frequency protection supervision block
// Assumes: frequency in 0.01 Hz units, phase-phase voltages in 0.1 V units
// Notes: register offsets are byte addresses on the AHB-Lite slave
package freq_prot_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_TIME_US = 10000;
    localparam int TICK_CYCLES = TICK_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int PRESCALE_WIDTH = 17;

    // ------------------------------------------------------------
    // frequency and voltage limits, stage and rate element counts
    // ------------------------------------------------------------
    localparam logic [15:0] TRACK_LOW = 16'h0fa0;
    localparam logic [15:0] TRACK_HIGH = 16'h1b58;
    localparam logic [4:0] HYST_DEN = 5'h14;
    localparam logic [4:0] HYST_NUM = 5'h15;
    localparam int STAGES = 6;
    localparam int ROC_ELEMENTS = 8;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] NOMINAL_ADDR = 8'h04;
    localparam logic [7:0] UV_THRESH_ADDR = 8'h08;
    localparam logic [7:0] ROC_CYCLES_ADDR = 8'h0c;
    localparam logic [7:0] HOLD_TIMER_ADDR = 8'h10;
    localparam logic [7:0] STATUS_ADDR = 8'h14;
    localparam logic [7:0] IRQ_STATUS_ADDR = 8'h18;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'h1c;
    localparam logic [7:0] STAGE_BASE_ADDR = 8'h20;
    localparam logic [7:0] STAGE_LAST_ADDR = 8'h4c;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int STAGE_EN_BIT = 31;
    localparam int DROPOFF_LSB = 8;
    localparam int IRQ_EVENTS = 5;

    // ------------------------------------------------------------
    // values after reset and setting limits
    // ------------------------------------------------------------
    localparam logic UV_ENABLE_RESET = 1'b1;
    localparam logic [15:0] NOMINAL_RESET = 16'h1388;
    localparam logic [15:0] UV_THRESH_RESET = 16'h00fa;
    localparam logic [3:0] PICKUP_RESET = 4'h5;
    localparam logic [3:0] PICKUP_MIN = 4'h1;
    localparam logic [3:0] PICKUP_MAX = 4'hc;
    localparam logic [1:0] DROPOFF_RESET = 2'h3;
    localparam logic [1:0] DROPOFF_MIN = 2'h1;
    localparam logic [8:0] HOLD_RESET = 9'h005;
    localparam logic [8:0] HOLD_MIN = 9'h001;
    localparam logic [8:0] HOLD_MAX = 9'h12c;
    localparam logic [5:0] STAGE_EN_RESET = 6'h3f;
    // stage 0 first: 49.00, 48.60, 48.20, 47.80, 50.50, 51.00 Hz
    localparam logic [5:0][15:0] STAGE_FREQ_RESET =
        {16'h13ec, 16'h13ba, 16'h12ac, 16'h12d4, 16'h12fc, 16'h1324};
    // stage 0 first: 20, 20, 10, 10, 30, 20 s in 0.01 s steps
    localparam logic [5:0][15:0] STAGE_DELAY_RESET =
        {16'h07d0, 16'h0bb8, 16'h03e8, 16'h03e8, 16'h07d0, 16'h07d0};

endpackage

// [testbench/freq_prot_assertions.sv]
// Purpose: port-level checks of the frequency protection block
// Assumes: flags are registered one cycle behind their inputs
// Notes: bound from the testbench top file
`timescale 1ns/1ps

module freq_prot_assertions (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [15:0] freq,
    input wire logic cycle_tick,
    input wire logic [7:0] roc_valid,
    input wire logic [5:0] stage_start,
    input wire logic [5:0] stage_trip,
    input wire logic any_start,
    input wire logic any_trip,
    input wire logic freq_below_range,
    input wire logic freq_above_range,
    input wire logic uv_block_active
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire logic roc_block = freq_below_range | freq_above_range | uv_block_active;

    property p_below;
        1'b1 |=> freq_below_range == $past(freq < 16'h0fa0);
    endproperty
    a_below: assert property (p_below)
        else $error("below flag");
    property p_above;
        1'b1 |=> freq_above_range == $past(freq > 16'h1b58);
    endproperty
    a_above: assert property (p_above)
        else $error("above flag");
    property p_any_start;
        any_start == (|stage_start);
    endproperty
    a_any_start: assert property (p_any_start)
        else $error("any start");
    property p_any_trip;
        any_trip == (|stage_trip);
    endproperty
    a_any_trip: assert property (p_any_trip)
        else $error("any trip");
    property p_uv_stages;
        uv_block_active ##1 uv_block_active |-> (stage_start == 6'h00) && (stage_trip == 6'h00);
    endproperty
    a_uv_stages: assert property (p_uv_stages)
        else $error("uv stages");
    property p_trip_needs_start;
        (stage_trip & ~stage_start) == 6'h00;
    endproperty
    a_trip_needs_start: assert property (p_trip_needs_start)
        else $error("trip no start");
    property p_roc_block;
        roc_block |=> roc_valid == 8'h00;
    endproperty
    a_roc_block: assert property (p_roc_block)
        else $error("roc not blocked");
    property p_roc_tick;
        !cycle_tick && !roc_block |=> $stable(roc_valid);
    endproperty
    a_roc_tick: assert property (p_roc_tick)
        else $error("roc no tick");
    c_trip: cover property (any_trip);
    c_uv: cover property (uv_block_active);
    c_roc: cover property (roc_valid != 8'h00);
endmodule // freq_prot_assertions

// [testbench/power_system_model.sv]
// Purpose: power system side, one tick per power cycle
// Assumes: levels of frequency and voltage are set by the bench
// Notes: cycle length shortened for simulation
`timescale 1ns/1ps

module power_system_model #(
    parameter int CYCLE_CLOCKS = 20
) (
    input wire logic sys_clk,
    input wire logic rst,
    output logic cycle_tick
);
    typedef struct packed {
        logic [7:0] count;
        logic tick;
    } model_state_type;
    model_state_type state, next_state;

    always_comb begin
        next_state = state;
        next_state.tick = (state.count == 8'(CYCLE_CLOCKS - 1));
        next_state.count = next_state.tick ? 8'h00 : state.count + 8'h01;
    end

    always_ff @(posedge sys_clk) begin
        state <= rst ? '0 : next_state;
    end
    assign cycle_tick = state.tick;
endmodule // power_system_model

// [testbench/tb_frequency_protection_supervision.sv]
// Purpose: directed tests over the register bus and measured inputs
// Assumes: zero wait state slave, tick every 20 clocks
// Notes: stage delays cut short
`timescale 1ns/1ps

module tb_frequency_protection_supervision;
    logic sys_clk, rst, hsel, hwrite, hreadyout, hresp, cycle_tick;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] freq, volt_ab, volt_bc, volt_ca;
    logic [7:0] roc_exceed, roc_valid;
    logic [8:0] holding_time;
    logic [5:0] stage_start, stage_trip;
    logic any_start, any_trip, freq_below_range, freq_above_range;
    logic uv_block_active, setting_invalid, irq;
    int err_count, n_tests, cycles;

    freq_protection_supervision #(.TICK_CYCLES(10)) u_freq_protection_supervision (
        .sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .freq, .volt_ab, .volt_bc,
        .volt_ca, .cycle_tick, .roc_exceed, .roc_valid, .holding_time, .stage_start,
        .stage_trip, .any_start, .any_trip, .freq_below_range, .freq_above_range,
        .uv_block_active, .setting_invalid, .irq);
    power_system_model u_power_system_model (.sys_clk, .rst, .cycle_tick);

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            give_verdict();
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        if (err_count == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        #1;
        rd = hrdata;
    endtask
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        chk_val(rd, exp);
    endtask
    // ab stays healthy, bc and ca both follow v: two low phases block
    task automatic drive(input logic [15:0] f, input logic [15:0] v);
        @(posedge sys_clk);
        freq <= f;
        volt_ab <= 16'h044c;
        volt_bc <= v;
        volt_ca <= v;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask
    task automatic wait_tick();
        do @(posedge sys_clk); while (cycle_tick !== 1'b1);
        #1;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0;
        hsize = 3'h2; hwdata = '0; freq = 16'h1388; volt_ab = 16'h044c;
        volt_bc = 16'h044c; volt_ca = 16'h044c; roc_exceed = 8'h00;
        err_count = 0; n_tests = 0; cycles = 0;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        chk_reg(8'h00, 32'h1);
        chk_reg(8'h0c, 32'h0305);
        chk_reg(8'h10, 32'h5);
        chk_reg(8'h50, 32'h0);
        for (int i = 0; i < 6; i++) begin
            chk_reg(8'(32 + 8 * i), {16'h8000, freq_prot_pkg::STAGE_FREQ_RESET[i]});
            chk_reg(8'(36 + 8 * i), {16'h0, freq_prot_pkg::STAGE_DELAY_RESET[i]});
        end
        ahb(1'b1, 8'h10, 32'h0);
        chk_val({23'h0, holding_time}, 32'h1);
        ahb(1'b1, 8'h10, 32'h12c);
        chk_val({23'h0, holding_time}, 32'h12c);
        drive(16'd3999, 16'd1100);
        chk_val({freq_below_range, freq_above_range, stage_start}, 32'h8f);
        drive(16'd7001, 16'd1100);
        chk_val({freq_below_range, freq_above_range}, 32'h1);
        drive(16'd4700, 16'd1100);
        chk_val({any_start, stage_start}, 32'h4f);
        drive(16'd5200, 16'd1100);
        chk_val({any_start, stage_start}, 32'h70);
        ahb(1'b1, 8'h24, 32'h0);
        ahb(1'b1, 8'h2c, 32'h3);
        drive(16'd4850, 16'd1100);
        chk_val({irq, any_trip, stage_trip, stage_start}, 32'h1043);
        for (int k = 0; k < 60 && stage_trip[1] !== 1'b1; k++) @(posedge sys_clk);
        #1;
        chk_val({26'h0, stage_trip}, 32'h3);
        ahb(1'b0, 8'h18, 32'h0);
        chk_val({31'h0, rd[0]}, 32'h1);
        ahb(1'b1, 8'h1c, 32'h1);
        chk_val({31'h0, irq}, 32'h1);
        drive(16'd5000, 16'd1100);
        chk_val({stage_trip, stage_start}, 32'h0);
        ahb(1'b1, 8'h18, 32'h1f);
        chk_val({31'h0, irq}, 32'h0);
        ahb(1'b1, 8'h20, 32'h80001388);
        drive(16'd4700, 16'd1100);
        chk_val({setting_invalid, stage_start}, 32'h4e);
        ahb(1'b1, 8'h20, 32'h80001324);
        drive(16'd4850, 16'd249);
        chk_val({uv_block_active, stage_start}, 32'h40);
        drive(16'd4850, 16'd262);
        chk_val({31'h0, uv_block_active}, 32'h1);
        drive(16'd4850, 16'd263);
        chk_val({uv_block_active, stage_start}, 32'h03);
        ahb(1'b1, 8'h00, 32'h0);
        drive(16'd4850, 16'd100);
        chk_val({31'h0, uv_block_active}, 32'h0);
        ahb(1'b1, 8'h00, 32'h1);
        drive(16'd5000, 16'd1100);
        ahb(1'b1, 8'h0c, 32'h010f);
        chk_reg(8'h0c, 32'h010c);
        ahb(1'b1, 8'h0c, 32'h0102);
        @(posedge sys_clk);
        roc_exceed <= 8'h81;
        wait_tick();
        chk_val({24'h0, roc_valid}, 32'h0);
        wait_tick();
        chk_val({24'h0, roc_valid}, 32'h81);
        @(posedge sys_clk);
        roc_exceed <= 8'h7e;
        wait_tick();
        chk_val({24'h0, roc_valid}, 32'h0);
        wait_tick();
        chk_val({24'h0, roc_valid}, 32'h7e);
        drive(16'd3999, 16'd1100);
        chk_val({24'h0, roc_valid}, 32'h0);
        give_verdict();
    end
endmodule // tb_frequency_protection_supervision

bind freq_protection_supervision freq_prot_assertions u_freq_prot_assertions (.sys_clk,
    .rst, .freq, .cycle_tick, .roc_valid, .stage_start, .stage_trip, .any_start,
    .any_trip, .freq_below_range, .freq_above_range, .uv_block_active);
